// ### core/bmps_pkg.sv
// Constants shared by the buck mode, sequencing and power-good logic
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package bmps_pkg;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE_CTRL  = 8'h47;
  localparam logic [7:0] ADDR_POLARITY   = 8'h5E;
  localparam int         MODE_PIN_LSB    = 4;
  localparam int         MODE_FORCE_LSB  = 0;
  localparam logic [7:0] MODE_CTRL_MASK  = 8'h77;
  localparam logic [7:0] MODE_CTRL_RST   = 8'h00;
  localparam int         POL_INV_BIT     = 0;
  localparam logic [7:0] POL_MASK        = 8'h01;
  localparam logic [7:0] POL_RST         = 8'h00;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int BIAS_DELAY_US     = 170;
  localparam int SOFT_START_US     = 250;
  localparam int BURST_MAX_US      = 7;
  localparam int BIAS_CYCLES       = (BIAS_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_CYCLES       = (SOFT_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_CYCLES      = BURST_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int PHASE_STEP_CYCLES = 25;

  // --------------------------------------------------------------------------
  // Sizes and states
  // --------------------------------------------------------------------------
  localparam int BUCK_N = 3;
  localparam int LDO_N  = 11;
  localparam int CNT_W  = 16;

  typedef enum logic [3:0] {
    SEQ_OFF  = 4'b0001,
    SEQ_BIAS = 4'b0010,
    SEQ_RAMP = 4'b0100,
    SEQ_ON   = 4'b1000
  } bmps_seq_state_type;

endpackage

// ### core/bmps_buck_seq.sv
// One buck converter: enable sequencing and automatic mode exit
`timescale 1ns/1ps
module bmps_buck_seq #(
  parameter int BIAS_CYCLES  = bmps_pkg::BIAS_CYCLES,
  parameter int RAMP_CYCLES  = bmps_pkg::RAMP_CYCLES,
  parameter int BURST_CYCLES = bmps_pkg::BURST_CYCLES
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic en_i,
  input  wire logic mode_fixed_i,
  // Converter feedback
  input  wire logic burst_i,
  input  wire logic low2_i,
  input  wire logic light_load_i,
  // Status
  output logic      on_o,
  output logic      ramp_o,
  output logic      fixed_freq_o
);

  // --------------------------------------------------------------------------
  // Enable sequencer
  // --------------------------------------------------------------------------
  localparam logic [bmps_pkg::CNT_W-1:0] BIAS_LAST  = bmps_pkg::CNT_W'(BIAS_CYCLES - 1);
  localparam logic [bmps_pkg::CNT_W-1:0] RAMP_LAST  = bmps_pkg::CNT_W'(RAMP_CYCLES - 1);
  localparam logic [bmps_pkg::CNT_W-1:0] BURST_LAST = bmps_pkg::CNT_W'(BURST_CYCLES - 1);

  bmps_pkg::bmps_seq_state_type state_ff;
  bmps_pkg::bmps_seq_state_type nxt_state;
  logic [bmps_pkg::CNT_W-1:0]   cnt_ff;
  logic [bmps_pkg::CNT_W-1:0]   nxt_cnt;
  logic [bmps_pkg::CNT_W-1:0]   burst_cnt_ff;
  logic                         forced_ff;
  logic                         exit_w;
  logic                         nxt_forced;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 1'b1;
    case (state_ff)
      bmps_pkg::SEQ_OFF: begin
        nxt_cnt = '0;
        if (en_i) begin
          nxt_state = bmps_pkg::SEQ_BIAS;
        end
      end
      bmps_pkg::SEQ_BIAS: begin
        if (!en_i) begin
          nxt_state = bmps_pkg::SEQ_OFF;
        end else if (cnt_ff == BIAS_LAST) begin
          nxt_state = bmps_pkg::SEQ_RAMP;
          nxt_cnt   = '0;
        end
      end
      bmps_pkg::SEQ_RAMP: begin
        if (!en_i) begin
          nxt_state = bmps_pkg::SEQ_OFF;
        end else if (cnt_ff == RAMP_LAST) begin
          nxt_state = bmps_pkg::SEQ_ON;
        end
      end
      bmps_pkg::SEQ_ON: begin
        nxt_cnt = '0;
        if (!en_i) begin
          nxt_state = bmps_pkg::SEQ_OFF;
        end
      end
      default: begin
        nxt_state = bmps_pkg::SEQ_OFF;
        nxt_cnt   = '0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Automatic mode exit
  // --------------------------------------------------------------------------
  // Exit wins over a light-load return in the same cycle
  assign exit_w     = !mode_fixed_i && on_o &&
                      (low2_i || (burst_i && burst_cnt_ff == BURST_LAST));
  assign nxt_forced = exit_w || (forced_ff && !light_load_i && on_o);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff     <= bmps_pkg::SEQ_OFF;
      cnt_ff       <= '0;
      burst_cnt_ff <= '0;
      forced_ff    <= 1'b0;
      on_o         <= 1'b0;
      ramp_o       <= 1'b0;
      fixed_freq_o <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      burst_cnt_ff <= burst_i ? burst_cnt_ff + 1'b1 : '0;
      forced_ff    <= nxt_forced;
      on_o         <= (nxt_state == bmps_pkg::SEQ_ON);
      ramp_o       <= (nxt_state == bmps_pkg::SEQ_RAMP);
      fixed_freq_o <= mode_fixed_i || nxt_forced;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  int bias_age_ff;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bias_age_ff <= 0;
    end else begin
      bias_age_ff <= (state_ff == bmps_pkg::SEQ_OFF) ? 0 : bias_age_ff + 1;
    end
  end

  property p_bias_delay;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_ff == bmps_pkg::SEQ_RAMP && $past(state_ff) == bmps_pkg::SEQ_BIAS) |-> bias_age_ff == BIAS_CYCLES;
  endproperty
  a_bias_delay: assert property (p_bias_delay) else $error("Bias delay length wrong");

  property p_low2_exit;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (on_o && en_i && !mode_fixed_i && low2_i) |=> fixed_freq_o;
  endproperty
  a_low2_exit: assert property (p_low2_exit) else $error("Low comparator did not force fixed mode");

  property p_burst_exit;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (on_o && en_i && !mode_fixed_i && burst_i && burst_cnt_ff == BURST_LAST) |=> fixed_freq_o;
  endproperty
  a_burst_exit: assert property (p_burst_exit) else $error("Long burst did not force fixed mode");

endmodule

// ### core/bmps_top.sv
// Buck mode select, discharge, sequencing, phasing and power-good logic
`timescale 1ns/1ps
module bmps_top #(
  parameter int BIAS_CYCLES       = bmps_pkg::BIAS_CYCLES,
  parameter int RAMP_CYCLES       = bmps_pkg::RAMP_CYCLES,
  parameter int PHASE_STEP_CYCLES = bmps_pkg::PHASE_STEP_CYCLES,
  parameter int LDO_N             = bmps_pkg::LDO_N
) (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_n_i,
  // Register port from the serial front end
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  output logic      [7:0]             reg_rdata_o,
  // System state
  input  wire logic                   mode_select_pin_i,
  input  wire logic                   run_state_active_i,
  input  wire logic                   rail_sequencing_state_i,
  input  wire logic                   vout_transition_i,
  input  wire logic                   battery_tracking_i,
  // Buck control and comparators
  input  wire logic [2:0]             buck_en_i,
  input  wire logic [2:0]             buck_uv90_i,
  input  wire logic [2:0]             buck_low2_i,
  input  wire logic [2:0]             buck_burst_i,
  input  wire logic [2:0]             buck_light_load_i,
  // LDO monitoring
  input  wire logic [LDO_N-1:0]       ldo_uv95_i,
  input  wire logic [LDO_N-1:0]       ldo_action_mode_i,
  // Buck outputs
  output logic      [2:0]             buck_fixed_freq_o,
  output logic      [2:0]             buck_discharge_o,
  output logic      [2:0]             buck_ramp_o,
  output logic      [2:0]             buck_on_o,
  output logic      [2:0]             buck_out_low_o,
  output logic      [2:0]             buck_phase_clk_o,
  // LDO outputs
  output logic      [LDO_N-1:0]       ldo_low_o,
  output logic                        ldo_irq_o,
  output logic                        ldo_mode_req_o
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Selected mode: 1 is fixed frequency, 0 is automatic switching
  function automatic logic sel_mode(input logic pin_ctrl, input logic force_ff_bit,
                                    input logic invert, input logic pin);
    sel_mode = pin_ctrl ? (pin ^ invert) : force_ff_bit;
  endfunction

  // Square clock with quarter-period offset per buck
  function automatic logic phase_level(input logic [1:0] quad, input logic [1:0] idx);
    logic [1:0] rel;
    rel         = quad - idx;
    phase_level = !rel[1];
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] mode_ctrl_ff;
  logic [7:0] polarity_ff;
  logic       wr_mode_w;
  logic       wr_pol_w;
  logic       hit_mode_w;
  logic       hit_pol_w;
  logic [7:0] rd_data_w;

  assign hit_mode_w = (reg_addr_i == bmps_pkg::ADDR_MODE_CTRL);
  assign hit_pol_w  = (reg_addr_i == bmps_pkg::ADDR_POLARITY);
  assign wr_mode_w  = reg_wr_i && hit_mode_w;
  assign wr_pol_w   = reg_wr_i && hit_pol_w;
  // Unmapped addresses read as zero
  assign rd_data_w  = hit_mode_w ? mode_ctrl_ff :
                      hit_pol_w  ? polarity_ff  : 8'h00;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ctrl_ff <= bmps_pkg::MODE_CTRL_RST;
      polarity_ff  <= bmps_pkg::POL_RST;
      reg_rdata_o  <= 8'h00;
    end else begin
      if (wr_mode_w) begin
        mode_ctrl_ff <= reg_wdata_i & bmps_pkg::MODE_CTRL_MASK;
      end
      if (wr_pol_w) begin
        polarity_ff <= reg_wdata_i & bmps_pkg::POL_MASK;
      end
      if (reg_rd_i) begin
        reg_rdata_o <= rd_data_w;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Mode selection and per-buck sequencing
  // --------------------------------------------------------------------------
  logic       pol_inv_w;
  logic [2:0] mode_fixed_w;
  logic [2:0] seq_on_w;
  logic [2:0] seq_ramp_w;
  logic [2:0] seq_fixed_w;

  assign pol_inv_w = polarity_ff[bmps_pkg::POL_INV_BIT];

  for (genvar k = 0; k < bmps_pkg::BUCK_N; k++) begin : g_buck
    assign mode_fixed_w[k] = sel_mode(mode_ctrl_ff[bmps_pkg::MODE_PIN_LSB + k],
                                      mode_ctrl_ff[bmps_pkg::MODE_FORCE_LSB + k],
                                      pol_inv_w, mode_select_pin_i);

    bmps_buck_seq #(
      .BIAS_CYCLES  (BIAS_CYCLES),
      .RAMP_CYCLES  (RAMP_CYCLES),
      .BURST_CYCLES (bmps_pkg::BURST_CYCLES)
    ) u_seq (
      .clk_sys_i    (clk_sys_i),
      .rst_n_i      (rst_n_i),
      .en_i         (buck_en_i[k]),
      .mode_fixed_i (mode_fixed_w[k]),
      .burst_i      (buck_burst_i[k]),
      .low2_i       (buck_low2_i[k]),
      .light_load_i (buck_light_load_i[k]),
      .on_o         (seq_on_w[k]),
      .ramp_o       (seq_ramp_w[k]),
      .fixed_freq_o (seq_fixed_w[k])
    );
  end

  // --------------------------------------------------------------------------
  // Discharge and power good
  // --------------------------------------------------------------------------
  logic       dis_enable_w;
  logic [2:0] pg_mask_w;
  logic [2:0] nxt_out_low;
  logic [2:0] nxt_discharge;

  // Outside run and sequencing the switches stay open to save quiescent current
  assign dis_enable_w  = run_state_active_i || rail_sequencing_state_i;
  assign nxt_discharge = ~buck_en_i & {3{dis_enable_w}};
  assign pg_mask_w     = {3{vout_transition_i}} | {battery_tracking_i, 2'b00};
  assign nxt_out_low   = buck_uv90_i & seq_on_w & ~pg_mask_w;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buck_discharge_o  <= 3'h0;
      buck_out_low_o    <= 3'h0;
      buck_fixed_freq_o <= 3'h0;
      buck_ramp_o       <= 3'h0;
      buck_on_o         <= 3'h0;
    end else begin
      buck_discharge_o  <= nxt_discharge;
      buck_out_low_o    <= nxt_out_low;
      buck_fixed_freq_o <= seq_fixed_w;
      buck_ramp_o       <= seq_ramp_w;
      buck_on_o         <= seq_on_w;
    end
  end

  // --------------------------------------------------------------------------
  // Phased clocking
  // --------------------------------------------------------------------------
  localparam logic [bmps_pkg::CNT_W-1:0] STEP_LAST = bmps_pkg::CNT_W'(PHASE_STEP_CYCLES - 1);

  logic [bmps_pkg::CNT_W-1:0] step_cnt_ff;
  logic [1:0]                 quad_ff;
  logic                       step_done_w;
  logic [2:0]                 nxt_phase_clk;

  assign step_done_w = (step_cnt_ff == STEP_LAST);

  for (genvar k = 0; k < bmps_pkg::BUCK_N; k++) begin : g_phase
    // Buck a is the master; b and c lag by one and two quarters
    assign nxt_phase_clk[k] = seq_on_w[k] && seq_fixed_w[k] &&
                              phase_level(quad_ff, 2'(k));
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_cnt_ff      <= '0;
      quad_ff          <= 2'h0;
      buck_phase_clk_o <= 3'h0;
    end else begin
      step_cnt_ff      <= step_done_w ? '0 : step_cnt_ff + 1'b1;
      quad_ff          <= step_done_w ? quad_ff + 2'h1 : quad_ff;
      buck_phase_clk_o <= nxt_phase_clk;
    end
  end

  // --------------------------------------------------------------------------
  // LDO power good
  // --------------------------------------------------------------------------
  logic [LDO_N-1:0] ldo_rise_w;

  assign ldo_rise_w = ldo_uv95_i & ~ldo_low_o;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ldo_low_o      <= '0;
      ldo_irq_o      <= 1'b0;
      ldo_mode_req_o <= 1'b0;
    end else begin
      ldo_low_o      <= ldo_uv95_i;
      ldo_irq_o      <= |(ldo_rise_w & ~ldo_action_mode_i);
      ldo_mode_req_o <= |(ldo_rise_w & ldo_action_mode_i);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_force_fixed;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!mode_ctrl_ff[bmps_pkg::MODE_PIN_LSB] && mode_ctrl_ff[bmps_pkg::MODE_FORCE_LSB])
        |=> ##1 buck_fixed_freq_o[0];
  endproperty
  a_force_fixed: assert property (p_force_fixed) else $error("Force bit did not give fixed mode");

  property p_pin_mode;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (mode_ctrl_ff[bmps_pkg::MODE_PIN_LSB + 1] && (mode_select_pin_i ^ pol_inv_w))
        |=> ##1 buck_fixed_freq_o[1];
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("Mode pin did not give fixed mode");

  property p_spare_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (reg_rd_i && hit_mode_w) |=> (reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0);
  endproperty
  a_spare_zero: assert property (p_spare_zero) else $error("Spare mode bits not zero");

  property p_discharge;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!buck_en_i[2] && run_state_active_i) |=> buck_discharge_o[2];
  endproperty
  a_discharge: assert property (p_discharge) else $error("Discharge switch not on");

  property p_pg_flag;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (buck_uv90_i[0] && seq_on_w[0] && !vout_transition_i) |=> buck_out_low_o[0];
  endproperty
  a_pg_flag: assert property (p_pg_flag) else $error("Output low not flagged");

  property p_pg_transition;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      vout_transition_i |=> (buck_out_low_o == 3'h0);
  endproperty
  a_pg_transition: assert property (p_pg_transition) else $error("Power good not masked");

  property p_pg_tracking;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      battery_tracking_i |=> !buck_out_low_o[2];
  endproperty
  a_pg_tracking: assert property (p_pg_tracking) else $error("Buck c power good not masked");

  property p_phase_opposed;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (seq_on_w[0] && seq_fixed_w[0] && seq_on_w[2] && seq_fixed_w[2]) |=>
        (buck_phase_clk_o[0] != buck_phase_clk_o[2]);
  endproperty
  a_phase_opposed: assert property (p_phase_opposed) else $error("Buck c not 180 degrees from a");

  property p_ldo_irq;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ldo_uv95_i[0] && !ldo_low_o[0] && !ldo_action_mode_i[0]) |=>
        ldo_irq_o ##1 (!ldo_irq_o || $past(|(ldo_rise_w & ~ldo_action_mode_i)));
  endproperty
  a_ldo_irq: assert property (p_ldo_irq) else $error("LDO low interrupt missing");

endmodule

// ### verif/bmps_host_model.sv
// Host side model that drives the register strobe port
`timescale 1ns/1ps
module bmps_host_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Register port towards the block
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // One-cycle write strobe; released lines carry inverted junk, not stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge clk_sys_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask

  // Read data is taken half a cycle after the read edge, once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_sys_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    @(negedge clk_sys_i);
    d = reg_rdata_i;
  endtask
endmodule

// ### verif/bmps_top_bench.sv
// Self-checking bench for the buck mode and power-good block
`timescale 1ns/1ps
module bmps_top_bench;
  localparam int BIAS = 8;
  localparam int RAMP = 12;
  typedef struct packed {
    logic [7:0] mode;
    logic       pol;
    logic       pin;
    logic [2:0] fix;
  } bmps_row_type;
  logic         clk_sys_i = 1'b0;
  logic         rst_n_i   = 1'b0;
  logic         wr, rd_s, pin_i = 1'b0, run_i = 1'b1, seq_i = 1'b0, trans_i = 1'b0, batt_i = 1'b0;
  logic [7:0]   addr, wdata, rdata, rd;
  logic [2:0]   en_i = 3'h0, uv90_i = 3'h0, low2_i = 3'h0, burst_i = 3'h0, light_i = 3'h7;
  logic [2:0]   fix_o, dis_o, ramp_o, on_o, low_o, ph_o;
  logic [2:0]   ph [24];
  logic [10:0]  ldo_uv_i = 11'h000, ldo_act_i = 11'h000, ldo_low_o;
  logic         irq_o, req_o;
  int           mismatches = 0;
  int           samples_checked = 0;
  int           n, r;
  bmps_row_type rows [9] = '{'{8'h00, 1'b0, 1'b0, 3'h0}, '{8'h07, 1'b0, 1'b0, 3'h7},
    '{8'h05, 1'b0, 1'b1, 3'h5}, '{8'h77, 1'b0, 1'b1, 3'h7}, '{8'h70, 1'b0, 1'b0, 3'h0},
    '{8'h70, 1'b1, 1'b0, 3'h7}, '{8'h70, 1'b1, 1'b1, 3'h0}, '{8'h47, 1'b0, 1'b0, 3'h3},
    '{8'h88, 1'b0, 1'b1, 3'h0}};

  always #5 clk_sys_i = ~clk_sys_i;

  bmps_host_model host (.clk_sys_i(clk_sys_i), .reg_wr_o(wr), .reg_rd_o(rd_s), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  bmps_top #(.BIAS_CYCLES(BIAS), .RAMP_CYCLES(RAMP), .PHASE_STEP_CYCLES(2)) DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .mode_select_pin_i(pin_i), .run_state_active_i(run_i),
    .rail_sequencing_state_i(seq_i), .vout_transition_i(trans_i), .battery_tracking_i(batt_i),
    .buck_en_i(en_i), .buck_uv90_i(uv90_i), .buck_low2_i(low2_i), .buck_burst_i(burst_i),
    .buck_light_load_i(light_i), .ldo_uv95_i(ldo_uv_i), .ldo_action_mode_i(ldo_act_i),
    .buck_fixed_freq_o(fix_o), .buck_discharge_o(dis_o), .buck_ramp_o(ramp_o), .buck_on_o(on_o),
    .buck_out_low_o(low_o), .buck_phase_clk_o(ph_o), .ldo_low_o(ldo_low_o), .ldo_irq_o(irq_o),
    .ldo_mode_req_o(req_o));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_neg(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run is about a thousand cycles; this leaves a wide margin
  initial begin
    #100000;
    mismatches++;
    $display("watchdog expired");
    test_done();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    host.rd(8'h47, rd);
    chk("mode reset", 11'h000, 11'(rd));
    host.rd(8'h13, rd);
    chk("unmapped read", 11'h000, 11'(rd));
    @(posedge clk_sys_i);
    en_i <= 3'h7;
    r = 0;
    for (n = 1; n < BIAS + RAMP + 10; n++) begin
      @(negedge clk_sys_i);
      if (r == 0 && ramp_o[0] === 1'b1) r = n;
      if (on_o[0] === 1'b1) break;
    end
    chk("ramp start window", 11'h001, 11'(r >= BIAS && r <= BIAS + 3));
    chk("on delay window", 11'h001, 11'(n >= BIAS + RAMP && n <= BIAS + RAMP + 4));
    $display("test done: sequencing");
    foreach (rows[i]) begin
      @(posedge clk_sys_i);
      pin_i <= rows[i].pin;
      host.wr(8'h5E, {7'h00, rows[i].pol});
      host.wr(8'h47, rows[i].mode);
      wait_neg(4);
      chk("fixed freq", 11'(rows[i].fix), 11'(fix_o));
      host.rd(8'h47, rd);
      chk("mode readback", 11'(rows[i].mode & 8'h77), 11'(rd));
    end
    $display("test done: mode table");
    host.wr(8'h5E, 8'hFF);
    host.rd(8'h5E, rd);
    chk("polarity readback", 11'h001, 11'(rd));
    host.wr(8'h5E, 8'h00);
    // Discharge follows enable only in run or sequencing state
    chk("discharge all on", 11'h000, 11'(dis_o));
    @(posedge clk_sys_i);
    en_i <= 3'h5;
    wait_neg(3);
    chk("discharge b off", 11'h002, 11'(dis_o));
    chk("on after drop", 11'h005, 11'(on_o));
    @(posedge clk_sys_i);
    run_i <= 1'b0;
    seq_i <= 1'b1;
    wait_neg(3);
    chk("discharge seq", 11'h002, 11'(dis_o));
    @(posedge clk_sys_i);
    seq_i <= 1'b0;
    wait_neg(3);
    chk("discharge idle", 11'h000, 11'(dis_o));
    @(posedge clk_sys_i);
    run_i <= 1'b1;
    en_i  <= 3'h7;
    wait_neg(BIAS + RAMP + 6);
    chk("restart on", 11'h007, 11'(on_o));
    $display("test done: discharge");
    @(posedge clk_sys_i);
    uv90_i <= 3'h7;
    wait_neg(3);
    chk("out low", 11'h007, 11'(low_o));
    @(posedge clk_sys_i);
    batt_i <= 1'b1;
    wait_neg(3);
    chk("out low tracking", 11'h003, 11'(low_o));
    @(posedge clk_sys_i);
    trans_i <= 1'b1;
    wait_neg(3);
    chk("out low transition", 11'h000, 11'(low_o));
    @(posedge clk_sys_i);
    trans_i <= 1'b0;
    batt_i  <= 1'b0;
    uv90_i  <= 3'h0;
    $display("test done: power good");
    // Automatic mode exits: short low-comparator pulse, then a long burst
    light_i <= 3'h0;
    host.wr(8'h47, 8'h00);
    @(posedge clk_sys_i);
    low2_i <= 3'h1;
    @(posedge clk_sys_i);
    low2_i <= 3'h0;
    wait_neg(5);
    chk("low comparator exit", 11'h001, 11'(fix_o));
    @(posedge clk_sys_i);
    light_i <= 3'h1;
    burst_i <= 3'h2;
    wait_neg(690);
    chk("burst too short", 11'h000, 11'(fix_o));
    wait_neg(14);
    chk("burst exit", 11'h002, 11'(fix_o));
    @(posedge clk_sys_i);
    burst_i <= 3'h0;
    light_i <= 3'h7;
    $display("test done: auto exit");
    host.wr(8'h47, 8'h07);
    wait_neg(6);
    for (int t = 0; t < 24; t++) begin
      @(negedge clk_sys_i);
      ph[t] = ph_o;
    end
    n = 0;
    r = 0;
    for (int t = 8; t < 24; t++) begin
      n += (ph[t][1] !== ph[t-2][0]) + (ph[t][2] !== ph[t-4][0]);
      r += (ph[t][0] === 1'b1);
    end
    chk("phase lag errors", 11'h000, 11'(n));
    chk("buck a high count", 11'h008, 11'(r));
    $display("test done: phasing");
    // LDO bit 0 reports by interrupt, bit 5 by mode request
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys_i);
      ldo_act_i <= 11'h020;
      ldo_uv_i  <= (k == 0) ? 11'h001 : 11'h021;
      n = 0;
      r = 0;
      repeat (4) begin
        @(negedge clk_sys_i);
        n += (irq_o === 1'b1);
        r += (req_o === 1'b1);
      end
      chk("ldo irq pulses", 11'(1 - k), 11'(n));
      chk("ldo req pulses", 11'(k), 11'(r));
    end
    chk("ldo low", 11'h021, ldo_low_o);
    $display("test done: ldo");
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    wait_neg(2);
    chk("fixed in reset", 11'h000, 11'(fix_o));
    chk("on in reset", 11'h000, 11'(on_o));
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    host.rd(8'h47, rd);
    chk("mode after reset", 11'h000, 11'(rd));
    $display("test done: second reset");
    test_done();
  end
endmodule
